// [pbcd_pin_model.sv]
`timescale 1ns/100ps
module pbcd_pin_model
(
   input  wire logic [7:0] dev_val_in,
   input  wire logic [7:0] dev_oe_n_in,
   input  wire logic [7:0] ext_in,
   output logic      [7:0] pin_out
);
   // a driven pin shows the device value, else the outside level
   assign pin_out = (dev_val_in & ~dev_oe_n_in) | (ext_in & dev_oe_n_in);
endmodule

// [pbcd_pkg.sv]
package pbcd_pkg;

   localparam int          PBCD_W           = 8;
   localparam int          PBCD_ALT_W       = 3;
   localparam logic [7:0]  PBCD_ZERO8       = 8'h00;
   localparam logic [7:0]  PBCD_LATCH_RST   = 8'h00;
   localparam logic [7:0]  PBCD_OE_N_RST    = 8'hff;
   localparam logic [7:0]  PBCD_LAST_POR    = 8'h00;

   // pin positions inside port b
   localparam int          PBCD_B0          = 0;
   localparam int          PBCD_B1          = 1;
   localparam int          PBCD_B3          = 3;
   localparam int          PBCD_B5          = 5;

   // positions inside the relocated-pin input group
   localparam int          PBCD_ALT_T3      = 0;
   localparam int          PBCD_ALT_U2      = 1;
   localparam int          PBCD_ALT_U3      = 2;

   // pwm2 b and unit 3: set = port b pin, clear = moved off; timer3 clock and unit 2: clear = port b pin
   typedef struct packed {
      logic pwm2_outb_route_fuse;
      logic unit3_route_fuse;
      logic timer3_clock_route_fuse;
      logic unit2_route_fuse;
   } pbcd_fuse_type;

   // peripheral outputs that want a pin
   typedef struct packed {
      logic unit4_en;
      logic unit4_val;
      logic pwm1_c_en;
      logic pwm1_c_val;
      logic sck_en;
      logic sck_val;
      logic unit2_en;
      logic unit2_val;
      logic unit3_en;
      logic unit3_val;
      logic pwm2b_en;
      logic pwm2b_val;
   } pbcd_periph_out_type;

   // pin levels handed to peripherals
   typedef struct packed {
      logic ext_external_interrupt_zero;
      logic unit4_capture;
      logic pwm_fault;
      logic sr_latch;
      logic serial2_ss;
      logic ext_external_interrupt_one;
      logic serial2_clock;
      logic timer3_clock;
      logic unit2_capture;
      logic unit3_capture;
   } pbcd_periph_in_type;

   typedef struct packed {
      logic analog12_en;
      logic analog10_en;
      logic comparator_inv_en;
   } pbcd_analog_type;

   // drive requests for functions moved off port b
   typedef struct packed {
      logic portc0_en;
      logic portc0_val;
      logic portc6_en;
      logic portc6_val;
      logic porte0_en;
      logic porte0_val;
   } pbcd_reloc_type;

   typedef struct packed {
      logic [7:0]          last_read;
      logic [7:0]          out_latch;
      logic [7:0]          pin_out;
      logic [7:0]          pin_oe_n;
      logic [7:0]          read_data;
      logic                change_flag;
      pbcd_periph_in_type  periph;
      pbcd_analog_type     analog;
      pbcd_reloc_type      reloc;
   } pbcd_state_type;

endpackage

// [pbcd_port_asserts.sv]
`timescale 1ns/100ps
module pbcd_port_asserts
   import pbcd_pkg::*;
(
   input wire logic                mclk_in,
   input wire logic                srst_in,
   input wire logic                por_in,
   input wire logic [7:0]          direction_bits_in,
   input wire logic [7:0]          analog_select_bits_in,
   input wire logic                data_read_in,
   input wire logic                data_write_in,
   input wire logic [7:0]          write_data_in,
   input wire logic                flag_clear_in,
   input wire logic                pkg_28pin_in,
   input wire pbcd_fuse_type       fuse_in,
   input wire pbcd_periph_out_type periph_out_in,
   input wire logic [7:0]          pin_out,
   input wire logic [7:0]          pin_oe_n_out,
   input wire logic [7:0]          read_data_out,
   input wire logic [7:0]          port_b_output_latch_out,
   input wire logic                port_change_flag_out,
   input wire pbcd_reloc_type      reloc_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in || por_in);
   // previous edge was out of reset, so $past sees live inputs
   logic run_reg;
   always_ff @(posedge mclk_in) run_reg <= !(srst_in || por_in);
   ////////////////////////////////////////////////////////////////
   a_flag_sticks: assert property (port_change_flag_out && !flag_clear_in |=> port_change_flag_out)
      else $error("change flag dropped without clear");
   a_read_gated: assert property (data_read_in |=>
      (read_data_out & ($past(analog_select_bits_in) | ~$past(direction_bits_in))) == 8'h00) else $error("read not gated");
   a_read_holds: assert property (!data_read_in |=> $stable(read_data_out))
      else $error("read data moved without read");
   a_oe_dir: assert property (run_reg |-> pin_oe_n_out == $past(direction_bits_in))
      else $error("output enable not following direction");
   a_latch_write: assert property (data_write_in |=> port_b_output_latch_out == $past(write_data_in))
      else $error("output latch not written");
   a_bit0_drive: assert property (run_reg && !$past(direction_bits_in[0]) && !$past(periph_out_in.unit4_en)
      |-> pin_out[0] == $past(port_b_output_latch_out[0])) else $error("bit 0 not driving latch");
   a_pwm2_reloc: assert property (run_reg && $past(pkg_28pin_in && !fuse_in.pwm2_outb_route_fuse)
      |-> reloc_out.portc0_en == $past(periph_out_in.pwm2b_en)) else $error("pwm2 b not moved");
   a_unit3_reloc: assert property (run_reg && $past(!pkg_28pin_in && !fuse_in.unit3_route_fuse)
      |-> reloc_out.porte0_en == $past(periph_out_in.unit3_en)) else $error("unit 3 not moved");
   c_clear_lost: cover property (port_change_flag_out && flag_clear_in);
   c_read_flag: cover property (data_read_in && port_change_flag_out);
   c_reloc_e0: cover property (reloc_out.porte0_en);
endmodule
bind pbcd_port_top pbcd_port_asserts u_pbcd_port_asserts (.*);

// [pbcd_port_top.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - while change-enabled pins differ from the last-read latch the change flag is set again every cycle, so a clear does not stick.
// - a read or write of the port data register reloads the latch from the pins, ending the mismatch.
// - the last-read latch ignores the ordinary reset, so a mismatch still sets the flag after it.
// - a pin change landing in the cycle of a port read is absorbed into the latch but still sets the flag in that cycle.
// - an access refreshes all eight latch bits at once, so a change on one pin may be lost while another is serviced.
// - on 28-pin parts pwm2 output b sits on bit 5 and moves to port c bit 0 when its fuse is cleared.
// - unit 3 sits on bit 5 and moves to port c bit 6 (28-pin) or port e bit 0 when its fuse is cleared.
// - clearing the timer3 fuse takes its clock from bit 5; clearing the unit 2 fuse puts unit 2 on bit 3.
// - with direction 0 bit 0 drives the output latch, or unit 4 while unit4_en is set, regardless of analog select.
// - with direction 1 a bit is a digital input that reads zero while its analog select is set.
// - bit 0 as digital input feeds interrupt 0, capture 4, pwm fault, sr latch and serial2 select; analog feeds channel 12.
// - bit 1 carries the serial2 clock out or in by direction, pwm1 output c, interrupt 1 and analog channel 10.
// - bits with no digital reading return zero.
// - capture 4 input on bit 0 needs analog select 0; the comparator inverting input on bit 1 needs analog select 1.

module pbcd_port_top
   import pbcd_pkg::*;
(
   input  wire logic                 mclk_in,
   input  wire logic                 srst_in,
   input  wire logic                 por_in,
   input  wire logic [7:0]           pin_in,
   input  wire logic [2:0]           alt_pin_in,
   input  wire logic [7:0]           direction_bits_in,
   input  wire logic [7:0]           analog_select_bits_in,
   input  wire logic [7:0]           change_enable_in,
   input  wire logic                 data_read_in,
   input  wire logic                 data_write_in,
   input  wire logic [7:0]           write_data_in,
   input  wire logic                 flag_clear_in,
   input  wire logic                 pkg_28pin_in,
   input  wire pbcd_fuse_type        fuse_in,
   input  wire pbcd_periph_out_type  periph_out_in,
   output logic      [7:0]           pin_out,
   output logic      [7:0]           pin_oe_n_out,
   output logic      [7:0]           read_data_out,
   output logic      [7:0]           port_b_output_latch_out,
   output logic                      port_change_flag_out,
   output pbcd_periph_in_type        periph_in_out,
   output pbcd_analog_type           analog_out,
   output pbcd_reloc_type            reloc_out
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PBCD_W+PBCD_ALT_W-1:0] sync_q;
   logic [7:0]                   pin_s;
   logic [2:0]                   alt_s;

   pbcd_sync #(.WIDTH(PBCD_W+PBCD_ALT_W)) u_sync
   (
      .mclk_in (mclk_in),
      .d_in    ({alt_pin_in, pin_in}),
      .q_out   (sync_q)
   );

   assign pin_s = sync_q[PBCD_W-1:0];
   assign alt_s = sync_q[PBCD_W+PBCD_ALT_W-1:PBCD_W];

   ////////////////////////////////////////////////////////////////////////////
   // state

   pbcd_state_type st_reg;
   pbcd_state_type st_next;

   always_comb
   begin
      logic [7:0] dig_in_en;
      logic [7:0] drv_en;
      logic [7:0] drv_val;
      logic       mismatch;
      logic       access;
      logic       u3_home;
      logic       pb2_home;
      dig_in_en = direction_bits_in & ~analog_select_bits_in;
      drv_en    = ~direction_bits_in;
      drv_val   = st_reg.out_latch;
      access    = data_read_in | data_write_in;
      u3_home   = fuse_in.unit3_route_fuse;
      pb2_home  = fuse_in.pwm2_outb_route_fuse & pkg_28pin_in;
      // compare against the latch as it stood before any access this cycle
      mismatch  = |((pin_s ^ st_reg.last_read) & change_enable_in);

      st_next = st_reg;

      // set wins over a clear in the same cycle
      st_next.change_flag = (st_reg.change_flag & ~flag_clear_in) | mismatch;

      // whole-port reload; a pin edge arriving now is latched here after setting the flag above
      if (access)
      begin
         st_next.last_read = pin_s;
      end

      if (data_write_in)
      begin
         st_next.out_latch = write_data_in;
      end

      // digital reads of analog pins return zero
      if (data_read_in)
      begin
         st_next.read_data = pin_s & dig_in_en;
      end

      ///////////////////////////////////////////////////////////////////////
      // output routing; peripherals win over the latch only in output mode

      if (periph_out_in.unit4_en)
      begin
         drv_val[PBCD_B0] = periph_out_in.unit4_val;
      end

      if (periph_out_in.sck_en)
      begin
         drv_val[PBCD_B1] = periph_out_in.sck_val;
      end
      else if (periph_out_in.pwm1_c_en)
      begin
         drv_val[PBCD_B1] = periph_out_in.pwm1_c_val;
      end

      if (periph_out_in.unit2_en && !fuse_in.unit2_route_fuse)
      begin
         drv_val[PBCD_B3] = periph_out_in.unit2_val;
      end

      // unit 3 takes bit 5 ahead of pwm2 output b when both sit at home
      if (periph_out_in.unit3_en && u3_home)
      begin
         drv_val[PBCD_B5] = periph_out_in.unit3_val;
      end
      else if (periph_out_in.pwm2b_en && pb2_home)
      begin
         drv_val[PBCD_B5] = periph_out_in.pwm2b_val;
      end

      st_next.pin_out  = drv_val & drv_en;
      st_next.pin_oe_n = ~drv_en;

      ///////////////////////////////////////////////////////////////////////
      // relocated outputs

      st_next.reloc.portc0_en  = periph_out_in.pwm2b_en & pkg_28pin_in &
                                 ~fuse_in.pwm2_outb_route_fuse;
      st_next.reloc.portc0_val = periph_out_in.pwm2b_val;
      st_next.reloc.portc6_en  = periph_out_in.unit3_en & ~u3_home & pkg_28pin_in;
      st_next.reloc.portc6_val = periph_out_in.unit3_val;
      st_next.reloc.porte0_en  = periph_out_in.unit3_en & ~u3_home & ~pkg_28pin_in;
      st_next.reloc.porte0_val = periph_out_in.unit3_val;

      ///////////////////////////////////////////////////////////////////////
      // inputs toward peripherals; port b pins gated to zero when not a digital input, relocated-pin inputs ungated

      st_next.periph.ext_external_interrupt_zero      = pin_s[PBCD_B0] & dig_in_en[PBCD_B0];
      st_next.periph.unit4_capture = pin_s[PBCD_B0] & dig_in_en[PBCD_B0];
      st_next.periph.pwm_fault     = pin_s[PBCD_B0] & dig_in_en[PBCD_B0];
      st_next.periph.sr_latch      = pin_s[PBCD_B0] & dig_in_en[PBCD_B0];
      st_next.periph.serial2_ss    = pin_s[PBCD_B0] & dig_in_en[PBCD_B0];
      st_next.periph.ext_external_interrupt_one      = pin_s[PBCD_B1] & dig_in_en[PBCD_B1];
      st_next.periph.serial2_clock = pin_s[PBCD_B1] & dig_in_en[PBCD_B1];

      st_next.periph.timer3_clock  = fuse_in.timer3_clock_route_fuse ?
                                     alt_s[PBCD_ALT_T3] :
                                     (pin_s[PBCD_B5] & dig_in_en[PBCD_B5]);
      st_next.periph.unit2_capture = fuse_in.unit2_route_fuse ?
                                     alt_s[PBCD_ALT_U2] :
                                     (pin_s[PBCD_B3] & dig_in_en[PBCD_B3]);
      st_next.periph.unit3_capture = u3_home ?
                                     (pin_s[PBCD_B5] & dig_in_en[PBCD_B5]) :
                                     alt_s[PBCD_ALT_U3];

      ///////////////////////////////////////////////////////////////////////
      // analog paths need input direction and analog select

      st_next.analog.analog12_en       = direction_bits_in[PBCD_B0] &
                                         analog_select_bits_in[PBCD_B0];
      st_next.analog.analog10_en       = direction_bits_in[PBCD_B1] &
                                         analog_select_bits_in[PBCD_B1];
      st_next.analog.comparator_inv_en = direction_bits_in[PBCD_B1] &
                                         analog_select_bits_in[PBCD_B1];

      ///////////////////////////////////////////////////////////////////////
      // resets; only power-on clears the last-read latch

      if (srst_in)
      begin
         st_next.out_latch   = PBCD_LATCH_RST;
         st_next.pin_out     = PBCD_ZERO8;
         st_next.pin_oe_n    = PBCD_OE_N_RST;
         st_next.read_data   = PBCD_ZERO8;
         st_next.change_flag = 1'h0;
         st_next.periph      = '0;
         st_next.analog      = '0;
         st_next.reloc       = '0;
         st_next.last_read   = st_reg.last_read;
      end

      if (por_in)
      begin
         st_next           = '0;
         st_next.pin_oe_n  = PBCD_OE_N_RST;
         st_next.last_read = PBCD_LAST_POR;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign pin_out                 = st_reg.pin_out;
   assign pin_oe_n_out            = st_reg.pin_oe_n;
   assign read_data_out           = st_reg.read_data;
   assign port_b_output_latch_out = st_reg.out_latch;
   assign port_change_flag_out    = st_reg.change_flag;
   assign periph_in_out           = st_reg.periph;
   assign analog_out              = st_reg.analog;
   assign reloc_out               = st_reg.reloc;

endmodule

// [pbcd_port_top_tb_top.sv]
`timescale 1ns/100ps
module pbcd_port_top_tb_top;
   import pbcd_pkg::*;
   logic                mclk = 1'b0, srst = 1'b1, por = 1'b1, rd = 1'b0, wr = 1'b0, clr = 1'b0, pkg = 1'b1;
   logic [7:0]          pins, ext = 8'h00, dir = 8'hff, ans = 8'h00, cen = 8'hff, wd = 8'h00;
   logic [7:0]          pv, oe, rdat, lat;
   logic [2:0]          alt = 3'h0;
   logic                flag;
   pbcd_fuse_type       fuse = 4'hf;
   pbcd_periph_out_type po = '0;
   pbcd_periph_in_type  pi;
   pbcd_analog_type     an;
   pbcd_reloc_type      rel;
   logic [7:0]          exp_q[$];
   int                  mismatches = 0, compares = 0, cycles = 0;
   always #25 mclk = ~mclk;
   pbcd_port_top u_pbcd_port_top (.mclk_in(mclk), .srst_in(srst), .por_in(por), .pin_in(pins), .alt_pin_in(alt),
      .direction_bits_in(dir), .analog_select_bits_in(ans), .change_enable_in(cen), .data_read_in(rd),
      .data_write_in(wr), .write_data_in(wd), .flag_clear_in(clr), .pkg_28pin_in(pkg), .fuse_in(fuse),
      .periph_out_in(po), .pin_out(pv), .pin_oe_n_out(oe), .read_data_out(rdat), .port_b_output_latch_out(lat),
      .port_change_flag_out(flag), .periph_in_out(pi), .analog_out(an), .reloc_out(rel));
   pbcd_pin_model u_pbcd_pin_model (.dev_val_in(pv), .dev_oe_n_in(oe), .ext_in(ext), .pin_out(pins));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] expv, input string what);
      compares++;
      if (seen !== expv)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, expv, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // read results are checked as they land, against the oldest note
   always @(posedge mclk)
   begin
      if (rd === 1'b1)
      begin
         #1;
         check(rdat, exp_q.pop_front(), "read_data_out");
      end
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(64));
      tick(17);
      check(oe, PBCD_OE_N_RST, "pin_oe_n_out");
      check(8'(flag), 8'h00, "port_change_flag_out");
      por = 1'b0;
      srst = 1'b0;
      ext = 8'($urandom) | 8'h01;
      tick(4);
      check(8'(flag), 8'h01, "port_change_flag_out");
      pulse(clr);
      check(8'(flag), 8'h01, "port_change_flag_out");
      exp_q.push_back(ext);
      pulse(rd);
      pulse(clr);
      check(8'(flag), 8'h00, "port_change_flag_out");
      $display("test mismatch done");
      // only ordinary resets keep the last-read latch
      ext = ext ^ 8'h80;
      tick(4);
      srst = 1'b1;
      tick(16);
      check(8'(flag), 8'h00, "port_change_flag_out");
      srst = 1'b0;
      tick(4);
      check(8'(flag), 8'h01, "port_change_flag_out");
      ext = 8'h00;
      por = 1'b1;
      tick(16);
      por = 1'b0;
      cen = 8'hfe;
      ext = 8'h01;
      tick(4);
      check(8'(flag), 8'h00, "port_change_flag_out");
      cen = 8'h00;
      $display("test reset latch done");
      // reads stay sparse, polling would hide pin changes
      repeat (8)
      begin
         ext = 8'($urandom);
         dir = 8'($urandom);
         ans = 8'($urandom);
         tick(5);
         exp_q.push_back(ext & dir & ~ans);
         pulse(rd);
         check(oe, dir, "pin_oe_n_out");
         check(8'({pi.ext_external_interrupt_zero, pi.unit4_capture, pi.pwm_fault, pi.sr_latch, pi.serial2_ss}),
            8'({5{ext[0] & dir[0] & ~ans[0]}}), "periph_in_out");
         check(8'({pi.ext_external_interrupt_one, pi.serial2_clock}), 8'({2{ext[1] & dir[1] & ~ans[1]}}), "periph_in_out");
         check(8'({an.analog12_en, an.analog10_en, an.comparator_inv_en}),
            8'({dir[0] & ans[0], {2{dir[1] & ans[1]}}}), "analog_out");
      end
      $display("test input gating done");
      dir = 8'h00;
      ans = 8'h01;
      wd = 8'($urandom);
      pulse(wr);
      tick(2);
      check(lat, wd, "port_b_output_latch_out");
      check(8'(pv[0]), 8'(wd[0]), "pin_out");
      $display("test output drive done");
      for (int p = 0; p < 2; p++)
      begin
         pkg = p[0];
         fuse = 4'h0;
         po = 12'($urandom);
         tick(2);
         check(8'({pv[5], pv[3]}), 8'({wd[5], po.unit2_en ? po.unit2_val : wd[3]}), "pin_out");
         if (p == 1)
            check(8'({rel.portc0_en, rel.portc0_val, rel.portc6_en, rel.portc6_val}),
               8'({po.pwm2b_en, po.pwm2b_val, po.unit3_en, po.unit3_val}), "reloc_out");
         else
            check(8'({rel.porte0_en, rel.porte0_val}), 8'({po.unit3_en, po.unit3_val}), "reloc_out");
      end
      dir = 8'hff;
      ans = 8'h00;
      ext = 8'h28;
      alt = 3'h4;
      tick(5);
      check(8'({pi.timer3_clock, pi.unit2_capture, pi.unit3_capture}), 8'h07, "periph_in_out");
      fuse = 4'hf;
      tick(5);
      check(8'({pi.timer3_clock, pi.unit2_capture, pi.unit3_capture}), 8'h01, "periph_in_out");
      $display("test routing done");
      stop_test();
   end
endmodule

// [pbcd_sync.sv]
`timescale 1ns/100ps

module pbcd_sync
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             mclk_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   // first stage feeds only the second
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } pbcd_sync_state_type;

   pbcd_sync_state_type st_reg;
   pbcd_sync_state_type st_next;

   always_comb
   begin
      st_next.meta = d_in;
      st_next.sync = st_reg.meta;
   end

   always_ff @(posedge mclk_in)
   begin
      st_reg <= st_next;
   end

   assign q_out = st_reg.sync;

endmodule
